// ### crtc_mode_ctrl.v
// CRT controller mode control: sync gating, address counter stepping,
// vertical clock divide, address mapping, split screen, readback regs.
// Assumes a host index/data port already decoded to one of 3B5h/3D5h,
// and character-clock, hretrace and line events as one-cycle enables.
`timescale 1ns/1ps
`include "crtc_defs.vh"

module crtc_mode_ctrl (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        arst_n,
    // Host controller data port, index already loaded
    input  wire [7:0]  crtc_index,
    input  wire        data_wr,
    input  wire        data_rd,
    input  wire [7:0]  data_wdata,
    output reg  [7:0]  data_rdata,
    // Fields held in neighbouring registers
    input  wire [7:0]  underline_location,
    input  wire [7:0]  max_scan_line,
    input  wire [7:0]  timing_overflow,
    input  wire [7:0]  start_addr_high,
    input  wire [7:0]  start_addr_low,
    input  wire [1:0]  read_map_select,
    input  wire        native_mode,
    // Memory read latches and attribute-controller port activity
    input  wire [31:0] mem_latches,
    input  wire        latch_load,
    input  wire        attr_index_wr,
    input  wire        attr_data_wr,
    // Timing events
    input  wire        char_clk_en,
    input  wire        hretrace_en,
    input  wire        line_start,
    input  wire        frame_start,
    input  wire        hsync_raw,
    input  wire        vsync_raw,
    input  wire [1:0]  row_scan,
    input  wire [9:0]  scan_line,
    // Outputs to display pipeline
    output reg         hsync_out,
    output reg         vsync_out,
    output reg         vcount_en,
    output reg  [15:0] decoder_addr_out,
    output reg  [15:0] count_addr_out,
    output wire [7:0]  crt_mode_control_out
);

    reg  [7:0]  crt_mode_control_q;
    reg  [7:0]  split_line_compare_low_q;
    reg  [31:0] latch_q;
    reg         attr_toggle_q;
    reg         vdiv_q;
    reg  [15:0] count_q;
    reg  [15:0] line_base_q;
    reg  [15:0] count_d;
    reg  [1:0]  adv_reload;

    wire [9:0]  line_compare;
    wire        split_hit;
    wire        adv_tick;
    wire [15:0] decoder_addr_in;
    wire [15:0] start_addr;
    wire [7:0]  latch_sel;

    assign crt_mode_control_out = crt_mode_control_q;
    assign start_addr = {start_addr_high, start_addr_low};

    // Host writes
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            crt_mode_control_q       <= `MODE_CTRL_RST;
            split_line_compare_low_q <= `LINE_CMP_RST;
        end else if (data_wr) begin
            if (crtc_index == `IDX_MODE_CTRL) begin
                crt_mode_control_q <= data_wdata;
                crt_mode_control_q[`MC_RESERVED] <= 1'b0;
            end
            if (crtc_index == `IDX_LINE_CMP_LOW) begin
                split_line_compare_low_q <= data_wdata;
            end
        end
    end

    // Memory read latches and attribute flip-flop state
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            latch_q       <= {4{`LATCH_DATA_RST}};
            attr_toggle_q <= 1'b0;
        end else begin
            if (latch_load) begin
                latch_q <= mem_latches;
            end
            // Data write wins if both strobes coincide
            if (attr_data_wr) begin
                attr_toggle_q <= 1'b1;
            end else if (attr_index_wr) begin
                attr_toggle_q <= 1'b0;
            end
        end
    end

    assign latch_sel = latch_q[{read_map_select, 3'b000} +: 8];

    // Register readback; unmapped indices read zero
    always @* begin
        case (crtc_index)
            `IDX_MODE_CTRL:    data_rdata = crt_mode_control_q;
            `IDX_LINE_CMP_LOW: data_rdata = split_line_compare_low_q;
            `IDX_LATCH_DATA:   data_rdata = latch_sel;
            `IDX_ATTR_TOGGLE:  data_rdata = {attr_toggle_q, 7'h00};
            default:           data_rdata = 8'h00;
        endcase
        if (!data_rd) begin
            data_rdata = 8'h00;
        end
    end

    // Syncs are forced inactive only in native modes
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            hsync_out <= 1'b0;
            vsync_out <= 1'b0;
        end else if (native_mode && !crt_mode_control_q[`MC_CTRL_RUN]) begin
            hsync_out <= 1'b0;
            vsync_out <= 1'b0;
        end else begin
            hsync_out <= hsync_raw;
            vsync_out <= vsync_raw;
        end
    end

    // Vertical counter clock, optionally halved
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            vdiv_q    <= 1'b0;
            vcount_en <= 1'b0;
        end else begin
            if (hretrace_en) begin
                vdiv_q <= ~vdiv_q;
            end
            if (crt_mode_control_q[`MC_VDIV2]) begin
                vcount_en <= hretrace_en && vdiv_q;
            end else begin
                vcount_en <= hretrace_en;
            end
        end
    end

    // Advance interval; count-by-2 takes precedence over count-by-4
    always @* begin
        if (crt_mode_control_q[`MC_COUNT_BY2]) begin
            adv_reload = `ADV_DIV2;
        end else if (underline_location[`UL_COUNT_BY4]) begin
            adv_reload = `ADV_DIV4;
        end else begin
            adv_reload = `ADV_DIV1;
        end
    end

    crtc_char_div u_char_div (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .ev      (char_clk_en),
        .clear   (line_start),
        .reload  (adv_reload),
        .tick    (adv_tick)
    );

    // Ten-bit compare value from three registers
    assign line_compare = {max_scan_line[`MSL_LINE_CMP_B9],
                           timing_overflow[`OVF_LINE_CMP_B8],
                           split_line_compare_low_q};
    assign split_hit = line_start && (scan_line == line_compare);

    // Memory address counter. Line base is loaded at frame start and cleared
    // on a compare hit, so the bottom part stays on byte zero for the frame.
    always @* begin
        count_d = count_q;
        if (frame_start) begin
            count_d = start_addr;
        end else if (split_hit) begin
            count_d = `ADDR_ZERO;
        end else if (line_start) begin
            count_d = line_base_q;
        end else if (adv_tick) begin
            count_d = count_q + 16'h0001;
        end
    end

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            count_q     <= `ADDR_ZERO;
            line_base_q <= `ADDR_ZERO;
        end else begin
            count_q <= count_d;
            if (frame_start) begin
                line_base_q <= start_addr;
            end else if (split_hit) begin
                line_base_q <= `ADDR_ZERO;
            end
        end
    end

    crtc_addr_map u_addr_map (
        .count_addr      (count_q),
        .row_scan        (row_scan),
        .dword_mode      (underline_location[`UL_DWORD_MODE]),
        .byte_mode       (crt_mode_control_q[`MC_BYTE_MODE]),
        .no_wrap         (crt_mode_control_q[`MC_NO_WRAP]),
        .no_rs1_sub      (crt_mode_control_q[`MC_NO_RS1_SUB]),
        .no_rs0_sub      (crt_mode_control_q[`MC_NO_RS0_SUB]),
        .decoder_addr_in (decoder_addr_in)
    );

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            decoder_addr_out <= `ADDR_ZERO;
            count_addr_out   <= `ADDR_ZERO;
        end else begin
            decoder_addr_out <= decoder_addr_in;
            count_addr_out   <= count_q;
        end
    end

endmodule

// ### crtc_defs.vh
// Constants for the CRT controller mode-control and address mapping block.
// Assumes inclusion by bare name from every design file of this block.
`ifndef CRTC_DEFS_VH
`define CRTC_DEFS_VH

// Controller data port index values
`define IDX_MODE_CTRL      8'h17
`define IDX_LINE_CMP_LOW   8'h18
`define IDX_LATCH_DATA     8'h22
`define IDX_ATTR_TOGGLE    8'h24

// Mode-control field positions
`define MC_CTRL_RUN        7
`define MC_BYTE_MODE       6
`define MC_NO_WRAP         5
`define MC_RESERVED        4
`define MC_COUNT_BY2       3
`define MC_VDIV2           2
`define MC_NO_RS1_SUB      1
`define MC_NO_RS0_SUB      0

// Underline-location and other source fields
`define UL_DWORD_MODE      6
`define UL_COUNT_BY4       5
`define MSL_LINE_CMP_B9    6
`define OVF_LINE_CMP_B8    4
`define ATTR_TOGGLE_BIT    7

// Reset values; undefined bits are cleared as a design choice
`define MODE_CTRL_RST      8'h00
`define LINE_CMP_RST       8'h00
`define LATCH_DATA_RST     8'h00

// Address bit positions for row-scan substitution
`define SUB_BIT_RS0        13
`define SUB_BIT_RS1        14

// Address-counter divider reload values (interval minus one)
`define ADV_DIV1           2'h0
`define ADV_DIV2           2'h1
`define ADV_DIV4           2'h3

`define ADDR_ZERO          16'h0000

`endif

// ### crtc_addr_map.v
// Reorganises the memory address counter into byte, word or dword form
// and then substitutes row-scan bits into bits 13 and 14.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`include "crtc_defs.vh"

module crtc_addr_map (
    // Counter and row scan
    input  wire [15:0] count_addr,
    input  wire [1:0]  row_scan,
    // Mode selects
    input  wire        dword_mode,
    input  wire        byte_mode,
    input  wire        no_wrap,
    input  wire        no_rs1_sub,
    input  wire        no_rs0_sub,
    // Decoder address
    output reg  [15:0] decoder_addr_in
);

    reg [15:0] reorganized_addr_out;

    always @* begin
        if (dword_mode) begin
            reorganized_addr_out = {count_addr[13:0],
                                    count_addr[13], count_addr[12]};
        end else if (byte_mode) begin
            reorganized_addr_out = count_addr;
        end else begin
            // Wrap bit picks the low bit source; 16 KB wrap when clear
            reorganized_addr_out = {count_addr[14:0],
                no_wrap ? count_addr[15] : count_addr[13]};
        end
        // Substitution happens only after reorganisation
        decoder_addr_in = reorganized_addr_out;
        if (!no_rs0_sub) begin
            decoder_addr_in[`SUB_BIT_RS0] = row_scan[0];
        end
        if (!no_rs1_sub) begin
            decoder_addr_in[`SUB_BIT_RS1] = row_scan[1];
        end
    end

endmodule

// ### crtc_char_div.v
// Divides an event stream by 1, 2 or 4, emitting one-cycle pulses.
// Assumes ev is a one-cycle pulse on ref_clk; clear restarts the count.
`timescale 1ns/1ps
`include "crtc_defs.vh"

module crtc_char_div (
    // Clock and reset
    input  wire       ref_clk,
    input  wire       arst_n,
    // Control
    input  wire       ev,
    input  wire       clear,
    input  wire [1:0] reload,
    // Divided pulse
    output wire       tick
);

    reg [1:0] cnt_q;

    assign tick = ev && (cnt_q >= reload);

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 2'h0;
        end else if (clear) begin
            cnt_q <= 2'h0;
        end else if (ev) begin
            cnt_q <= tick ? 2'h0 : cnt_q + 2'h1;
        end
    end

endmodule

// ### host_model.sv
// Host processor model driving the controller index/data port.
// Assumes the index already selects the 3B5h/3D5h data port.
`timescale 1ns/1ps
module host_model (
    // Clock
    input  wire       ref_clk,
    // Data port
    output reg  [7:0] crtc_index,
    output reg        data_wr,
    output reg        data_rd,
    output reg  [7:0] data_wdata,
    input  wire [7:0] data_rdata
);
    initial begin
        crtc_index = 8'h00;
        data_wr    = 1'b0;
        data_rd    = 1'b0;
        data_wdata = 8'h00;
    end
    // The write is taken at the edge that sees data_wr high
    task wr(input [7:0] idx, input [7:0] val);
        begin
            @(posedge ref_clk);
            crtc_index <= idx;
            data_wdata <= val;
            data_wr    <= 1'b1;
            @(posedge ref_clk);
            data_wr    <= 1'b0;
            // Released bus shows no stale value
            data_wdata <= ~val;
        end
    endtask
    task rd(input [7:0] idx, output [7:0] val);
        begin
            @(posedge ref_clk);
            crtc_index <= idx;
            data_rd    <= 1'b1;
            @(posedge ref_clk);
            val = data_rdata;
            data_rd    <= 1'b0;
        end
    endtask
endmodule

// ### crtc_mode_ctrl_monitor.sv
// Checker for the mode-control block, watching its top-level ports.
// Assumes syncs and vcount_en are registered one cycle after the cause.
`timescale 1ns/1ps
module crtc_mode_ctrl_monitor (
    // Clock and reset
    input wire       ref_clk,
    input wire       arst_n,
    // Host port
    input wire [7:0] crtc_index,
    input wire       data_wr,
    input wire       data_rd,
    input wire [7:0] data_wdata,
    input wire [7:0] data_rdata,
    // Syncs and vertical clock
    input wire       native_mode,
    input wire       hsync_raw,
    input wire       vsync_raw,
    input wire       hretrace_en,
    input wire       hsync_out,
    input wire       vsync_out,
    input wire       vcount_en,
    input wire [7:0] crt_mode_control_out
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    wire [7:0] mc = crt_mode_control_out;
    property p_gate;
        native_mode && !mc[7] |=> !hsync_out && !vsync_out;
    endproperty
    a_gate: assert property (p_gate) else $error("sync not gated");
    property p_pass;
        mc[7] || !native_mode |=> hsync_out == $past(hsync_raw)
            && vsync_out == $past(vsync_raw);
    endproperty
    a_pass: assert property (p_pass) else $error("sync blocked");
    property p_bit4;
        mc[4] == 1'b0;
    endproperty
    a_bit4: assert property (p_bit4) else $error("bit 4 set");
    property p_mc_wr;
        data_wr && crtc_index == 8'h17 |=> mc == ($past(data_wdata) & 8'hEF);
    endproperty
    a_mc_wr: assert property (p_mc_wr) else $error("mode write lost");
    property p_rd_mc;
        data_rd && crtc_index == 8'h17 |-> data_rdata == mc;
    endproperty
    a_rd_mc: assert property (p_rd_mc) else $error("mode readback");
    property p_tog;
        data_rd && crtc_index == 8'h24 |-> data_rdata[6:0] == 7'h00;
    endproperty
    a_tog: assert property (p_tog) else $error("toggle low bits");
    property p_lc;
        data_wr && crtc_index == 8'h18 ##2 data_rd && crtc_index == 8'h18
            |-> data_rdata == $past(data_wdata, 2);
    endproperty
    a_lc: assert property (p_lc) else $error("compare readback");
    property p_vc;
        vcount_en |-> $past(hretrace_en);
    endproperty
    a_vc: assert property (p_vc) else $error("stray vcount");
    property p_v1;
        !mc[2] && hretrace_en |=> vcount_en;
    endproperty
    a_v1: assert property (p_v1) else $error("vcount missed");
    c_gate: cover property (native_mode && !mc[7] && hsync_raw);
    c_vdiv: cover property (mc[2] && vcount_en);
    c_latch: cover property (data_rd && crtc_index == 8'h22);
endmodule

bind crtc_mode_ctrl crtc_mode_ctrl_monitor mon (.ref_clk, .arst_n,
    .crtc_index, .data_wr, .data_rd, .data_wdata, .data_rdata, .native_mode,
    .hsync_raw, .vsync_raw, .hretrace_en, .hsync_out, .vsync_out,
    .vcount_en, .crt_mode_control_out);

// ### tb_top.sv
// Testbench for the CRT mode-control block: host port, syncs, addressing.
// Assumes host_model drives the data port; the checker is bound apart.
`timescale 1ns/1ps
module tb_top;
    // Bench-driven inputs
    reg         ref_clk = 1'b0;
    reg         arst_n = 1'b0;
    reg  [7:0]  underline_location = 8'h00, max_scan_line = 8'h00;
    reg  [7:0]  timing_overflow = 8'h00;
    reg  [1:0]  read_map_select = 2'h0;
    reg  [31:0] mem_latches = 32'h44332211;
    reg         native_mode = 1'b1, hsync_raw = 1'b1, vsync_raw = 1'b1;
    reg  [6:0]  evs = 7'h00;
    reg  [9:0]  scan_line = 10'h3FF;
    // Host port and outputs
    wire [7:0]  crtc_index, data_wdata, data_rdata, crt_mode_control_out;
    wire        data_wr, data_rd, hsync_out, vsync_out, vcount_en;
    wire [15:0] decoder_addr_out, count_addr_out;
    reg  [7:0]  v;
    reg  [15:0] n = 16'h0000, n0;
    integer     bad_count = 0, total_checks = 0, i;
    localparam [15:0] START = 16'h65C3;
    localparam [55:0] MC = 56'hC3A38383A081C2;
    localparam [6:0]  DW = 7'b0001010;
    localparam [15:0] STEP = 16'h2124;
    localparam [29:0] SL = {10'h3FF, 10'h334, 10'h234};
    always #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (vcount_en === 1'b1) n <= n + 16'h0001;
    host_model host (.ref_clk, .crtc_index, .data_wr, .data_rd,
        .data_wdata, .data_rdata);
    crtc_mode_ctrl dut (.ref_clk, .arst_n, .crtc_index, .data_wr, .data_rd,
        .data_wdata, .data_rdata, .underline_location, .max_scan_line,
        .timing_overflow, .start_addr_high(8'h65), .start_addr_low(8'hC3),
        .read_map_select, .native_mode, .mem_latches, .latch_load(evs[2]),
        .attr_index_wr(evs[1]), .attr_data_wr(evs[0]), .char_clk_en(evs[4]),
        .hretrace_en(evs[3]), .line_start(evs[5]), .frame_start(evs[6]),
        .hsync_raw, .vsync_raw, .row_scan(2'h2), .scan_line, .hsync_out,
        .vsync_out, .vcount_en, .decoder_addr_out, .count_addr_out,
        .crt_mode_control_out);
    task chk(input [15:0] seen, input [15:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
            end
        end
    endtask
    task rchk(input [7:0] idx, input [7:0] exp);
        begin
            host.rd(idx, v);
            chk({8'h00, v}, {8'h00, exp});
        end
    endtask
    // One-cycle pulse on the selected event inputs
    task ev(input [6:0] m);
        begin
            @(posedge ref_clk);
            evs <= m;
            @(posedge ref_clk);
            evs <= 7'h00;
        end
    endtask
    task waitc(input integer c);
        repeat (c) @(posedge ref_clk);
    endtask
    task done(input string s);
        $display("%s finished, %0d mismatches so far", s, bad_count);
    endtask
    task finish_test;
        begin
            $display("Checks %0d, mismatches %0d", total_checks, bad_count);
            if (bad_count == 0 && total_checks > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    // Shift first, then substitute row scan (row scan held at 2'h2)
    function [15:0] exp_map(input integer k);
        reg [7:0] m;
        begin
            m = MC[8*k +: 8];
            exp_map = DW[k] ? {START[13:0], START[13:12]} : m[6] ? START
                : {START[14:0], m[5] ? START[15] : START[13]};
            if (!m[0]) exp_map[13] = 1'b0;
            if (!m[1]) exp_map[14] = 1'b1;
        end
    endfunction
    initial begin
        #200000;
        bad_count = bad_count + 1;
        finish_test;
    end
    initial begin
        waitc(6);
        arst_n <= 1'b1;
        rchk(8'h17, 8'h00);
        rchk(8'h22, 8'h00);
        rchk(8'h24, 8'h00);
        host.wr(8'h17, 8'hFF);
        rchk(8'h17, 8'hEF);
        rchk(8'h30, 8'h00);
        done("reset");
        host.wr(8'h17, 8'h03);
        waitc(2);
        chk({hsync_out, vsync_out}, 16'h0000);
        native_mode <= 1'b0;
        waitc(2);
        chk({hsync_out, vsync_out}, 16'h0003);
        hsync_raw <= 1'b0;
        waitc(2);
        chk({hsync_out, vsync_out}, 16'h0001);
        hsync_raw <= 1'b1;
        native_mode <= 1'b1;
        host.wr(8'h17, 8'h83);
        waitc(2);
        chk({hsync_out, vsync_out}, 16'h0003);
        done("sync");
        for (i = 0; i < 7; i = i + 1) begin
            underline_location <= {1'b0, DW[i], 6'h00};
            host.wr(8'h17, MC[8*i +: 8]);
            ev(7'h40);
            waitc(3);
            chk(count_addr_out, START);
            chk(decoder_addr_out, exp_map(i));
        end
        done("address map");
        for (i = 0; i < 4; i = i + 1) begin
            underline_location <= {2'b00, i[1], 5'h00};
            host.wr(8'h17, {4'h8, i[0], 3'h3});
            ev(7'h40);
            ev(7'h20);
            repeat (4) ev(7'h10);
            waitc(3);
            chk(count_addr_out, START + {12'h000, STEP[4*i +: 4]});
        end
        done("count step");
        host.wr(8'h18, 8'h34);
        rchk(8'h18, 8'h34);
        max_scan_line <= 8'h40;
        timing_overflow <= 8'h10;
        ev(7'h40);
        for (i = 0; i < 3; i = i + 1) begin
            scan_line <= SL[10*i +: 10];
            ev(7'h20);
            waitc(3);
            chk(count_addr_out, i == 0 ? START : 16'h0000);
        end
        ev(7'h40);
        waitc(3);
        chk(count_addr_out, START);
        done("split");
        ev(7'h04);
        host.wr(8'h22, 8'hFF);
        for (i = 0; i < 4; i = i + 1) begin
            read_map_select <= i[1:0];
            rchk(8'h22, mem_latches[8*i +: 8]);
        end
        ev(7'h01);
        rchk(8'h24, 8'h80);
        ev(7'h02);
        rchk(8'h24, 8'h00);
        // Coinciding index and data writes leave the data-port state
        ev(7'h03);
        rchk(8'h24, 8'h80);
        done("latch and toggle");
        for (i = 0; i < 2; i = i + 1) begin
            host.wr(8'h17, {5'h10, i[0], 2'h3});
            n0 = n;
            repeat (4) ev(7'h08);
            waitc(2);
            chk(n - n0, 16'h0004 >> i);
        end
        done("vertical");
        finish_test;
    end
endmodule
